// >>> hdl/acg_pkg.sv
/*
 * Constants and types of the converter control block: register
 * addresses, field positions, reset values, codes and states.
 * Assumes nothing of its surroundings; compiled before all modules.
 */
package acg_pkg;

    // ****************************************************
    // Register addresses
    // ****************************************************
    localparam logic [31:0] ADDR_CTRL = 32'hffff_0500;
    localparam logic [31:0] ADDR_POS = 32'hffff_0504;
    localparam logic [31:0] ADDR_NEG = 32'hffff_0508;
    localparam logic [31:0] ADDR_STAT = 32'hffff_050c;
    localparam logic [31:0] ADDR_RES = 32'hffff_0510;
    localparam logic [31:0] ADDR_SRST = 32'hffff_0514;
    localparam logic [31:0] ADDR_GAIN = 32'hffff_0520;

    // ****************************************************
    // Control word fields and reset values
    // ****************************************************
    localparam logic [15:0] CTRL_RESET = 16'h0a00;
    localparam logic [15:0] CTRL_MASK = 16'hffbf;
    localparam int TRIG_LSB = 0;
    localparam int MODE_LSB = 3;
    localparam int PWR_BIT = 5;
    localparam int EN_BIT = 7;
    localparam int ACQ_LSB = 8;
    localparam int DIV_LSB = 11;
    localparam int NBYP_BIT = 14;
    localparam int PBYP_BIT = 15;
    localparam int DONE_BIT = 0;
    localparam int SRST_BIT = 0;

    // ****************************************************
    // Trigger and mode codes
    // ****************************************************
    localparam logic [2:0] TRIG_PIN = 3'h0;
    localparam logic [2:0] TRIG_TMR1 = 3'h1;
    localparam logic [2:0] TRIG_TMR0 = 3'h2;
    localparam logic [2:0] TRIG_SINGLE = 3'h3;
    localparam logic [2:0] TRIG_CONT = 3'h4;
    localparam logic [2:0] TRIG_PLA = 3'h5;
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DIFF = 2'h1;
    localparam logic [1:0] MODE_PSEUDO = 2'h2;

    // ****************************************************
    // Channels, result and gain
    // ****************************************************
    localparam int CHAN_W = 5;
    localparam logic [4:0] NEG_AMP0 = 5'h00;
    localparam logic [4:0] NEG_AMP1 = 5'h01;
    localparam logic [4:0] NEG_ANALOG_GROUND = 5'h0e;
    localparam logic [4:0] NEG_IO_GROUND = 5'h10;
    localparam int RES_W = 12;
    localparam int RES_LSB = 16;
    localparam int GAIN_W = 6;
    localparam int GAIN0_LSB = 6;
    localparam int GAIN1_LSB = 0;
    localparam logic [5:0] GAIN_MAX = 6'h20;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam logic [2:0] SEL_MAX = 3'h5;
    localparam logic [7:0] ACQ_BASE = 8'h02;
    localparam logic [2:0] COMP_SETTLE = 3'h4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACQ = 2'b01,
        ST_CONV = 2'b10
    } acg_state_t;

endpackage

// >>> hdl/acg_pin_sync.sv
/*
 * Three-stage synchroniser for one pin level.
 * Assumes an asynchronous input; the level changes once the
 * second and third stages agree.
 */
`timescale 1ns/100ps

module acg_pin_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pin
    input wire logic pin_in,
    output logic level_out
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } acg_sync_t;

    acg_sync_t sync_reg;
    acg_sync_t sync_next;

    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = pin_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        if (sync_reg.s2 == sync_reg.s3) begin
            sync_next.level = sync_reg.s3;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign level_out = sync_reg.level;

endmodule

// >>> hdl/acg_tick_gen.sv
/*
 * Converter clock enable: one-cycle pulse every 2^n core cycles.
 * Assumes the divider select is a core-clock register value.
 */
`timescale 1ns/100ps

module acg_tick_gen (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Divider select and pulse
    input wire logic [2:0] div_sel_in,
    output logic tick_out
);

    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } acg_tick_t;

    acg_tick_t tick_reg;
    acg_tick_t tick_next;
    logic [2:0] sel;
    logic [4:0] last;

    always_comb begin
        sel = (div_sel_in > acg_pkg::SEL_MAX) ? acg_pkg::SEL_MAX
                                              : div_sel_in;
        last = 5'((6'h01 << sel) - 6'h01);
        tick_next = tick_reg;
        if (tick_reg.cnt >= last) begin
            tick_next.cnt = '0;
            tick_next.tick = 1'b1;
        end else begin
            tick_next.cnt = tick_reg.cnt + 5'h01;
            tick_next.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg.tick;

endmodule

// >>> hdl/acg_adc_ctrl.sv
/*
 * Converter control: AHB-Lite register slave, channel selection,
 * trigger choice and successive approximation sequencer.
 * Assumes a single-slave AHB-Lite bus on clk_in, an analog mux and
 * capacitive DAC driven from the outputs, and an asynchronous
 * comparator result and conversion-start pin.
 */
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/100ps

// How it works
// - Negative selector: 5-bit code, bits 7:5 reserved
// - Finished conversion sets status bit 0
// - Reading result clears status bit 0
// - Result code sits in bits 27:16
// - Soft reset bit restores all register defaults
// - Gain codes in bits 11:6 and 5:0
// - Gain is one plus four code over 32
// - Differential uses positive and negative selections
// - Acquire, then disconnect and approximate to completion
// - Single-ended ties negative side to ground
// - Eleven fixed and two amplified positive channels
// - Positive selector: 5-bit code in bits 4:0
// - Single software conversion returns trigger to 000

module acg_adc_ctrl (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Conversion triggers
    input wire logic convst_pin_in,
    input wire logic timer0_in,
    input wire logic timer1_in,
    input wire logic pla_in,
    // Analog side
    input wire logic comparator_in,
    output logic [4:0] pos_channel_out,
    output logic [4:0] neg_channel_out,
    output logic [1:0] conv_mode_out,
    output logic sample_out,
    output logic [11:0] dac_trial_out,
    output logic adc_power_out,
    output logic pos_bypass_out,
    output logic neg_bypass_out,
    output logic [5:0] amp0_gain_code_out,
    output logic [5:0] amp1_gain_code_out,
    output logic busy_out
);

    // ****************************************************
    // State
    // ****************************************************
    typedef struct packed {
        logic [15:0] ctrl;
        logic [4:0] pos;
        logic [4:0] neg;
        logic done;
        logic [11:0] result;
        logic [11:0] gain;
        logic [31:0] addr;
        logic wr_pend;
        logic rd_pend;
        logic ready;
        logic [31:0] rdata;
        acg_pkg::acg_state_t state;
        logic [6:0] acq_cnt;
        logic [3:0] bit_idx;
        logic [11:0] trial;
        logic [2:0] settle;
        logic pin_prev;
    } acg_ctrl_t;

    acg_ctrl_t ctrl_reg;
    acg_ctrl_t ctrl_next;

    logic tick;
    logic pin_level;
    logic comp_level;
    logic [2:0] trig;
    logic [1:0] mode;
    logic [2:0] acq_sel;
    logic [6:0] acq_last;
    logic enabled;
    logic start;
    logic accept;
    logic [31:0] rd_word;
    logic [11:0] keep;

    // ****************************************************
    // Converter clock enable and synchronisers
    // ****************************************************
    acg_tick_gen u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .div_sel_in(ctrl_reg.ctrl[acg_pkg::DIV_LSB +: 3]),
        .tick_out(tick)
    );

    acg_pin_sync u_convst_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(convst_pin_in),
        .level_out(pin_level)
    );

    acg_pin_sync u_comp_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(comparator_in),
        .level_out(comp_level)
    );

    // ****************************************************
    // Next state
    // ****************************************************
    always_comb begin
        ctrl_next = ctrl_reg;
        trig = ctrl_reg.ctrl[acg_pkg::TRIG_LSB +: 3];
        mode = ctrl_reg.ctrl[acg_pkg::MODE_LSB +: 2];
        acq_sel = ctrl_reg.ctrl[acg_pkg::ACQ_LSB +: 3];
        if (acq_sel > acg_pkg::SEL_MAX) begin
            acq_sel = acg_pkg::SEL_MAX;
        end
        acq_last = 7'((acg_pkg::ACQ_BASE << acq_sel) - 8'h01);
        enabled = ctrl_reg.ctrl[acg_pkg::EN_BIT]
                  && ctrl_reg.ctrl[acg_pkg::PWR_BIT];
        accept = hsel_in && htrans_in[1] && hready_in;
        rd_word = '0;
        keep = ctrl_reg.trial;
        ctrl_next.pin_prev = pin_level;

        // Trigger source select
        case (trig)
            acg_pkg::TRIG_PIN: begin
                start = pin_level && !ctrl_reg.pin_prev;
            end
            acg_pkg::TRIG_TMR1: begin
                start = timer1_in;
            end
            acg_pkg::TRIG_TMR0: begin
                start = timer0_in;
            end
            acg_pkg::TRIG_SINGLE: begin
                start = 1'b1;
            end
            acg_pkg::TRIG_CONT: begin
                start = 1'b1;
            end
            acg_pkg::TRIG_PLA: begin
                start = pla_in;
            end
            default: begin
                start = 1'b0;
            end
        endcase

        // Read data phase: one wait state, then data
        case (ctrl_reg.addr)
            acg_pkg::ADDR_CTRL: begin
                rd_word = 32'(ctrl_reg.ctrl);
            end
            acg_pkg::ADDR_POS: begin
                rd_word = 32'(ctrl_reg.pos);
            end
            acg_pkg::ADDR_NEG: begin
                rd_word = 32'(ctrl_reg.neg);
            end
            acg_pkg::ADDR_STAT: begin
                rd_word = 32'(ctrl_reg.done) << acg_pkg::DONE_BIT;
            end
            acg_pkg::ADDR_RES: begin
                rd_word = 32'(ctrl_reg.result) << acg_pkg::RES_LSB;
            end
            acg_pkg::ADDR_GAIN: begin
                rd_word = 32'(ctrl_reg.gain);
            end
            default: begin
                rd_word = '0;
            end
        endcase
        if (ctrl_reg.rd_pend && !ctrl_reg.ready) begin
            ctrl_next.rdata = rd_word;
            ctrl_next.ready = 1'b1;
            ctrl_next.rd_pend = 1'b0;
            if (ctrl_reg.addr == acg_pkg::ADDR_RES) begin
                ctrl_next.done = 1'b0;
            end
        end

        // Conversion sequencer
        case (ctrl_reg.state)
            acg_pkg::ST_IDLE: begin
                if (enabled && start) begin
                    ctrl_next.state = acg_pkg::ST_ACQ;
                    ctrl_next.acq_cnt = '0;
                end
            end
            acg_pkg::ST_ACQ: begin
                if (tick) begin
                    if (ctrl_reg.acq_cnt >= acq_last) begin
                        ctrl_next.state = acg_pkg::ST_CONV;
                        ctrl_next.bit_idx = 4'(acg_pkg::RES_W - 1);
                        ctrl_next.trial = 12'h800;
                        ctrl_next.settle = acg_pkg::COMP_SETTLE;
                    end else begin
                        ctrl_next.acq_cnt = ctrl_reg.acq_cnt + 7'h01;
                    end
                end
            end
            acg_pkg::ST_CONV: begin
                if (ctrl_reg.settle != '0) begin
                    ctrl_next.settle = ctrl_reg.settle - 3'h1;
                end else if (tick) begin
                    if (!comp_level) begin
                        keep[ctrl_reg.bit_idx] = 1'b0;
                    end
                    if (ctrl_reg.bit_idx == '0) begin
                        ctrl_next.result = keep;
                        ctrl_next.done = 1'b1;
                        ctrl_next.state = acg_pkg::ST_IDLE;
                        if (trig == acg_pkg::TRIG_SINGLE) begin
                            ctrl_next.ctrl[acg_pkg::TRIG_LSB +: 3] =
                                acg_pkg::TRIG_PIN;
                        end
                    end else begin
                        keep[ctrl_reg.bit_idx - 4'h1] = 1'b1;
                        ctrl_next.bit_idx = ctrl_reg.bit_idx - 4'h1;
                        ctrl_next.settle = acg_pkg::COMP_SETTLE;
                    end
                    ctrl_next.trial = keep;
                end
            end
            default: begin
                ctrl_next.state = acg_pkg::ST_IDLE;
            end
        endcase
        if (!enabled) begin
            ctrl_next.state = acg_pkg::ST_IDLE;
        end

        // Write data phase
        if (ctrl_reg.wr_pend) begin
            ctrl_next.wr_pend = 1'b0;
            case (ctrl_reg.addr)
                acg_pkg::ADDR_CTRL: begin
                    ctrl_next.ctrl = hwdata_in[15:0]
                                     & acg_pkg::CTRL_MASK;
                end
                acg_pkg::ADDR_POS: begin
                    ctrl_next.pos = hwdata_in[acg_pkg::CHAN_W-1:0];
                end
                acg_pkg::ADDR_NEG: begin
                    ctrl_next.neg = hwdata_in[acg_pkg::CHAN_W-1:0];
                end
                acg_pkg::ADDR_GAIN: begin
                    ctrl_next.gain = hwdata_in[11:0];
                end
                acg_pkg::ADDR_SRST: begin
                    if (hwdata_in[acg_pkg::SRST_BIT]) begin
                        ctrl_next.ctrl = acg_pkg::CTRL_RESET;
                        ctrl_next.pos = '0;
                        ctrl_next.neg = '0;
                        ctrl_next.done = 1'b0;
                        ctrl_next.result = '0;
                        ctrl_next.gain = '0;
                        ctrl_next.state = acg_pkg::ST_IDLE;
                        ctrl_next.trial = '0;
                    end
                end
                default: begin
                    ctrl_next.wr_pend = 1'b0;
                end
            endcase
        end

        // Address phase capture
        if (accept) begin
            ctrl_next.addr = haddr_in;
            ctrl_next.wr_pend = hwrite_in;
            ctrl_next.rd_pend = !hwrite_in;
            ctrl_next.ready = hwrite_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg <= '0;
            ctrl_reg.ctrl <= acg_pkg::CTRL_RESET;
            ctrl_reg.ready <= 1'b1;
            ctrl_reg.state <= acg_pkg::ST_IDLE;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign hrdata_out = ctrl_reg.rdata;
    assign hreadyout_out = ctrl_reg.ready;
    assign hresp_out = 1'b0;

    // Positive side always from the positive selector
    assign pos_channel_out = ctrl_reg.pos;

    // Negative side from the selector unless single-ended
    always_comb begin
        if (ctrl_reg.ctrl[acg_pkg::MODE_LSB +: 2]
            == acg_pkg::MODE_SINGLE) begin
            neg_channel_out = acg_pkg::NEG_ANALOG_GROUND;
        end else begin
            neg_channel_out = ctrl_reg.neg;
        end
    end

    assign conv_mode_out = mode;
    assign sample_out = (ctrl_reg.state == acg_pkg::ST_ACQ);
    assign dac_trial_out = ctrl_reg.trial;
    assign adc_power_out = ctrl_reg.ctrl[acg_pkg::PWR_BIT];
    assign pos_bypass_out = ctrl_reg.ctrl[acg_pkg::PBYP_BIT];
    assign neg_bypass_out = ctrl_reg.ctrl[acg_pkg::NBYP_BIT];
    assign busy_out = (ctrl_reg.state != acg_pkg::ST_IDLE);

    // Gain codes, held at most 32 for gains 1 to 5
    always_comb begin
        amp0_gain_code_out =
            ctrl_reg.gain[acg_pkg::GAIN0_LSB +: acg_pkg::GAIN_W];
        amp1_gain_code_out =
            ctrl_reg.gain[acg_pkg::GAIN1_LSB +: acg_pkg::GAIN_W];
        if (amp0_gain_code_out > acg_pkg::GAIN_MAX) begin
            amp0_gain_code_out = acg_pkg::GAIN_MAX;
        end
        if (amp1_gain_code_out > acg_pkg::GAIN_MAX) begin
            amp1_gain_code_out = acg_pkg::GAIN_MAX;
        end
    end

endmodule

// >>> testbench/acg_sar_model.sv
/*
 * Comparator model of the analog mux and SAR core.
 * Assumes the trial word and sample level come from the block.
 */
`timescale 1ns/100ps

module acg_sar_model (
    // Clock
    input wire logic clk_in,
    // Converter side
    input wire logic sample_in,
    input wire logic busy_in,
    input wire logic [11:0] trial_in,
    input wire logic [11:0] vin_in,
    output logic comp_out
);
    // ****************************************************
    // Track, hold and compare
    // ****************************************************
    logic [11:0] held_reg = 12'h0;
    logic tog_reg = 1'b0;

    // Track while sampling, hold once disconnected
    always @(posedge clk_in) begin
        tog_reg <= ~tog_reg;
        if (sample_in) begin
            held_reg <= vin_in;
        end
    end

    // Valid only in conversion, churns otherwise
    always_comb begin
        if (busy_in && !sample_in) begin
            comp_out = (held_reg >= trial_in);
        end else begin
            comp_out = tog_reg;
        end
    end
endmodule

// >>> testbench/acg_adc_ctrl_asserts.sv
/*
 * Port checker for the converter control block.
 * Assumes binding to acg_adc_ctrl on its single clock.
 */
`timescale 1ns/100ps

module acg_adc_ctrl_chk (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    // Analog side
    input wire logic [4:0] neg_channel_out,
    input wire logic [1:0] conv_mode_out,
    input wire logic sample_out,
    input wire logic [5:0] amp0_gain_code_out,
    input wire logic [5:0] amp1_gain_code_out,
    input wire logic busy_out
);
    // ****************************************************
    // Properties
    // ****************************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic take;
    assign take = hsel_in & htrans_in[1] & hready_in;

    property p_rd_wait;
        take && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out;
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read wait wrong");
    property p_wr_ready;
        take && hwrite_in |=> hreadyout_out;
    endproperty
    a_wr_ready: assert property (p_wr_ready)
        else $error("write stalled");
    property p_neg_gnd;
        conv_mode_out == 2'h0 |-> neg_channel_out == 5'h0e;
    endproperty
    a_neg_gnd: assert property (p_neg_gnd)
        else $error("single-ended negative not ground");
    property p_gain0;
        amp0_gain_code_out <= 6'h20;
    endproperty
    a_gain0: assert property (p_gain0)
        else $error("gain 0 above 32");
    property p_gain1;
        amp1_gain_code_out <= 6'h20;
    endproperty
    a_gain1: assert property (p_gain1)
        else $error("gain 1 above 32");
    property p_acq_busy;
        sample_out |-> busy_out;
    endproperty
    a_acq_busy: assert property (p_acq_busy)
        else $error("sampling while idle");
    property p_start_acq;
        $rose(busy_out) |-> sample_out;
    endproperty
    a_start_acq: assert property (p_start_acq)
        else $error("conversion without acquisition");
    property p_disconnect;
        $fell(sample_out) && busy_out |-> !sample_out [*8];
    endproperty
    a_disconnect: assert property (p_disconnect)
        else $error("input reconnected in conversion");

    c_done: cover property ($fell(busy_out));
    c_read: cover property (take && !hwrite_in);
    c_diff: cover property (conv_mode_out == 2'h1 && busy_out);
endmodule

bind acg_adc_ctrl acg_adc_ctrl_chk u_chk (.clk_in, .rst_n_in, .hsel_in,
    .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .neg_channel_out,
    .conv_mode_out, .sample_out, .amp0_gain_code_out, .amp1_gain_code_out,
    .busy_out);

// >>> testbench/tb_adc_channel_status_gain_control.sv
/*
 * Self-checking bench: AHB-Lite master tasks and scenarios.
 * Assumes acg_adc_ctrl, its checker and the SAR model compiled.
 */
`timescale 1ns/100ps

module tb_adc_channel_status_gain_control;
    // ****************************************************
    // Signals
    // ****************************************************
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic hsel_in = 1'b0;
    logic hwrite_in = 1'b0;
    logic [1:0] htrans_in = 2'h0;
    logic [31:0] haddr_in = 32'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic [3:0] trg = 4'h0;
    logic [11:0] vin = 12'h0;
    logic [31:0] q, hrdata_out;
    logic hreadyout_out, hresp_out, comparator_in, sample_out, busy_out;
    logic adc_power_out, pos_bypass_out, neg_bypass_out;
    logic [4:0] pos_channel_out, neg_channel_out;
    logic [1:0] conv_mode_out;
    logic [11:0] dac_trial_out;
    logic [5:0] amp0_gain_code_out, amp1_gain_code_out;
    int err_count = 0;
    int checks = 0;
    logic [31:0] ra [6] = '{acg_pkg::ADDR_NEG, acg_pkg::ADDR_STAT,
        acg_pkg::ADDR_RES, acg_pkg::ADDR_SRST, acg_pkg::ADDR_GAIN,
        acg_pkg::ADDR_POS};
    logic [4:0] nc [4] = '{5'h00, 5'h01, 5'h0e, 5'h10};
    logic [11:0] vt [3] = '{12'ha5c, 12'hfff, 12'h000};
    logic [2:0] tc [4] = '{3'h1, 3'h2, 3'h5, 3'h0};

    always #10 clk_in = ~clk_in;

    acg_adc_ctrl DUT (.clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
        .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
        .hrdata_out, .hreadyout_out, .hresp_out, .convst_pin_in(trg[3]),
        .timer0_in(trg[1]), .timer1_in(trg[0]), .pla_in(trg[2]),
        .comparator_in, .pos_channel_out, .neg_channel_out, .conv_mode_out,
        .sample_out, .dac_trial_out, .adc_power_out, .pos_bypass_out,
        .neg_bypass_out, .amp0_gain_code_out, .amp1_gain_code_out,
        .busy_out);

    acg_sar_model SAR (.clk_in, .sample_in(sample_out), .busy_in(busy_out),
        .trial_in(dac_trial_out), .vin_in(vin), .comp_out(comparator_in));

    // ****************************************************
    // Tasks
    // ****************************************************
    task end_sim;
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", s, e, g);
            err_count++;
        end
    endtask

    task waitfor(input bit bsy, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while ((bsy ? busy_out : hreadyout_out) !== v && n < lim);
        if ((bsy ? busy_out : hreadyout_out) !== v) begin
            $display("BAD wait busy %b exp %b", bsy, v);
            err_count++;
            end_sim;
        end
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_in <= 1'b1;
        haddr_in <= a;
        hwrite_in <= w;
        htrans_in <= 2'h2;
        waitfor(0, 1'b1, 50);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        waitfor(0, 1'b1, 50);
        q = hrdata_out;
    endtask

    task wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("rd %h", a), e, q);
        chk("resp", 32'h0, 32'(hresp_out));
    endtask

    task conv;
        waitfor(1, 1'b1, 100);
        waitfor(1, 1'b0, 3000);
        rd(ra[1], 32'h1);
        rd(ra[2], {4'h0, vin, 16'h0});
        rd(ra[1], 32'h0);
    endtask

    // ****************************************************
    // Scenarios
    // ****************************************************
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        wr(ra[1], 32'h1);
        wr(ra[2], 32'hffff_ffff);
        wr(32'hffff_0518, 32'hffff_ffff);
        rd(32'hffff_0518, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], 32'h0);
        end
        wr(acg_pkg::ADDR_CTRL, 32'hc028);
        for (int i = 0; i < 4; i++) begin
            wr(ra[0], 32'(nc[i]));
            wr(ra[5], {27'h0, ~nc[i]});
            @(negedge clk_in);
            chk("neg", 32'(nc[i]), 32'(neg_channel_out));
            chk("pos", {27'h0, ~nc[i]}, 32'(pos_channel_out));
            @(posedge clk_in);
        end
        chk("pwr", 32'h1, 32'(adc_power_out));
        chk("byp", 32'h3, 32'({pos_bypass_out, neg_bypass_out}));
        wr(ra[0], 32'hff);
        rd(ra[0], 32'h1f);
        wr(ra[5], 32'hff);
        rd(ra[5], 32'h1f);
        wr(acg_pkg::ADDR_CTRL, 32'h0);
        @(negedge clk_in);
        chk("neg", 32'he, 32'(neg_channel_out));
        chk("pos", 32'h1f, 32'(pos_channel_out));
        @(posedge clk_in);
        wr(ra[4], 32'hffff);
        rd(ra[4], 32'hfff);
        @(negedge clk_in);
        chk("amp0", 32'h20, 32'(amp0_gain_code_out));
        chk("amp1", 32'h20, 32'(amp1_gain_code_out));
        @(posedge clk_in);
        wr(ra[4], 32'h81f);
        @(negedge clk_in);
        chk("amp0", 32'h20, 32'(amp0_gain_code_out));
        chk("amp1", 32'h1f, 32'(amp1_gain_code_out));
        @(posedge clk_in);
        // Negative input for the differential and pseudo mode runs
        wr(ra[5], 32'h3);
        wr(ra[0], 32'hc);
        for (int m = 0; m < 3; m++) begin
            vin = vt[m];
            wr(acg_pkg::ADDR_CTRL, 32'ha3 | (m << 3));
            conv();
            rd(acg_pkg::ADDR_CTRL, 32'ha0 | (m << 3));
        end
        for (int k = 0; k < 4; k++) begin
            vin = vt[k % 3] ^ 12'h5a5;
            wr(acg_pkg::ADDR_CTRL, {29'h14, tc[k]});
            trg <= 4'h1 << k;
            repeat (k / 3 + 1) @(posedge clk_in);
            trg <= 4'h0;
            conv();
        end
        wr(ra[4], 32'h123);
        wr(ra[3], 32'h0);
        rd(ra[4], 32'h123);
        wr(acg_pkg::ADDR_CTRL, 32'ha4);
        repeat (10) @(posedge clk_in);
        wr(ra[3], 32'h1);
        @(negedge clk_in);
        chk("busy", 32'h0, 32'(busy_out));
        chk("trial", 32'h0, 32'(dac_trial_out));
        @(posedge clk_in);
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], 32'h0);
        end
        rd(acg_pkg::ADDR_CTRL, 32'ha00);
        end_sim;
    end
endmodule
